// ---- pcr_checker_sva.sv ----
/*
 * Port assertions for the power control block.
 * Assumes one clock domain and a bind from the bench top file.
 */
`timescale 1ns/1ps
`default_nettype none

module pcr_checker (
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire logic I_SCL,
  input wire logic I_UNDERVOLTAGE_LOCKOUT,
  input wire logic I_OVERTEMP,
  input wire logic [1:0] I_PEAK_LIMIT,
  input wire logic [1:0] I_ZERO_CURRENT,
  input wire logic O_SDA_OUT,
  input wire logic O_SDA_OE,
  input wire logic O_EN_PIN_OE,
  input wire logic [2:0] O_REG_ENABLE,
  input wire logic O_SHUTDOWN_OUT_N,
  input wire logic O_SW_CLK,
  input wire logic O_EXT_SYNC_ACTIVE,
  input wire logic [1:0] O_HS_ON,
  input wire logic [1:0] O_LS_ON
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SRST);
  ////////////////////////////////////////
  reset_out_a: assert property (
    $fell(I_SRST) |-> O_REG_ENABLE == 3'h0 && !O_EN_PIN_OE && O_SHUTDOWN_OUT_N)
    else $error("outputs wrong after reset");
  // Five cycles cover the two-stage synchroniser plus the register
  undervoltage_lockout_gate_a: assert property (
    I_UNDERVOLTAGE_LOCKOUT [*5] |-> O_REG_ENABLE == 3'h0)
    else $error("regulator on during lockout");
  thermal_gate_a: assert property (
    I_OVERTEMP [*5] |-> O_REG_ENABLE == 3'h0)
    else $error("regulator on during overtemperature");
  sw_clk_idle_a: assert property (
    !O_EXT_SYNC_ACTIVE [*2] |-> !O_SW_CLK)
    else $error("switching clock runs without valid select");
  sda_low_only_a: assert property (
    O_SDA_OE |-> O_SDA_OUT == 1'b0)
    else $error("data line driven high");
  sda_stable_a: assert property (
    $changed(O_SDA_OE) |-> !I_SCL && !$past(I_SCL))
    else $error("data changed while bus clock high");
  limit_hold_a: assert property (
    (I_PEAK_LIMIT[0] && O_REG_ENABLE[0] && !I_ZERO_CURRENT[0]) [*4]
    |-> !O_HS_ON[0] && O_LS_ON[0])
    else $error("switch state wrong in current limit");
  no_shoot_a: assert property (
    (O_HS_ON & O_LS_ON) == 2'b00)
    else $error("both switches on");
endmodule

`default_nettype wire

// ---- pcr_control_regs.sv ----
/*
 * Control logic of an imaging-module power unit: serial-bus slave with its
 * register bank, regulator enables, thermal fault handling, undervoltage
 * gating, pin-enable sequencing and the switching control block.
 * Assumes bus lines, analog flags and the enable pin are asynchronous pins
 * and that fuse values are stable while reset is applied.
 */
// Summary of operation
// (RQ1) 9.6 MHz sync selected: divide by three
// (RQ2) 19.2 MHz sync selected: divide by six
// (RQ3) Coupling bit: one ac, zero dc
// (RQ4) Slave only, 100 or 400 kHz bus
// (RQ5) Answers fixed seven-bit address 0010100
// (RQ6) Address last bit: one read, zero write
// (RQ7) Undervoltage lockout keeps all converters off
// (RQ8) Overtemperature disables outputs until it clears
// (RQ9) Thermal event latches fault flag in 0x04
// (RQ10) Fault flag set blocks enable bit writes
// (RQ11) Host clears flag before enabling regulators
// (RQ12) Command mode: outputs stay off after recovery
// (RQ13) Fault withholds acknowledge after a command
// (RQ14) Writing flag one acts as thermal shutdown
// (RQ15) Pin high: automatic restart and power-up sequence
// (RQ16) Flag stays set after automatic recovery
// (RQ17) Current limit: high side off, low on
// (RQ18) Revision register read-only, three fields
// (RQ19) Buck A voltage code fuse-loaded, writable
// (RQ20) Host sets operation control over the bus
// (RQ21) Enable pin input after reset, output optional
// (RQ22) Write: address, index, data; read via restart
`timescale 1ns/1ps
`default_nettype none

module pcr_control_regs
  import pcr_pkg::*;
#(
  parameter logic [2:0] MAJOR_REV = 3'h1, // Arbitrary value
  parameter logic [2:0] MINOR_REV = 3'h0, // Arbitrary value
  parameter logic [1:0] OPTION_CODE = 2'h0 // Arbitrary value
)(
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire logic I_SCL,
  input wire logic I_SDA,
  output logic O_SDA_OUT,
  output logic O_SDA_OE,
  input wire logic I_EN_PIN,
  output logic O_EN_PIN_OUT,
  output logic O_EN_PIN_OE,
  input wire logic I_UNDERVOLTAGE_LOCKOUT,
  input wire logic I_OVERTEMP,
  input wire logic [2:0] I_POWER_GOOD,
  input wire logic [2:0] I_FUSE_BUCK_A_VCODE,
  input wire logic [3:0] I_FUSE_BUCK_B_VCODE,
  input wire logic [3:0] I_FUSE_LINEAR_VCODE,
  input wire logic I_SYNC,
  input wire logic [1:0] I_PWM,
  input wire logic [1:0] I_PEAK_LIMIT,
  input wire logic [1:0] I_ZERO_CURRENT,
  output logic [2:0] O_REG_ENABLE,
  output logic O_SHUTDOWN_OUT_N,
  output logic [2:0] O_BUCK_A_VCODE,
  output logic [3:0] O_BUCK_B_VCODE,
  output logic [3:0] O_LINEAR_VCODE,
  output logic O_SYNC_COUPLING_AC_SELECT_SELECT,
  output logic O_SW_CLK,
  output logic O_EXT_SYNC_ACTIVE,
  output logic [1:0] O_HS_ON,
  output logic [1:0] O_LS_ON
);

  pcr_state_t r;
  pcr_state_t n;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic fault_active;
  logic pin_enable_mode;

  function automatic logic [7:0] read_reg(input pcr_state_t s);
    logic [7:0] v;
    v = 8'h00;
    unique case (s.idx)
      PCR_OFS_REVISION: v = {MAJOR_REV, MINOR_REV, OPTION_CODE}; // RQ18
      PCR_OFS_BUCK_A_VSEL: v = {5'h00, s.vsel_a};
      PCR_OFS_BUCK_B_LIN_VSEL: v = {s.vsel_b, s.vsel_l};
      PCR_OFS_REG_EN_STATUS: v = {s.cmd_en, s.pg_s2[0], s.pg_s2[1], s.pg_s2[2], s.force_sd};
      PCR_OFS_OP_CTRL: v = {1'b0, s.sync_sel, s.link, s.thermal_fault_flag};
      PCR_OFS_EN_PIN_CTRL: v = {6'h00, s.pin_drive_active, s.pin_drive_level};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Edge and bus-condition detection on the second synchroniser stage only
  assign scl_rise = r.scl_s2 && !r.scl_d;
  assign scl_fall = !r.scl_s2 && r.scl_d;
  assign start_cond = r.scl_s2 && r.scl_d && !r.sda_s2 && r.sda_d;
  assign stop_cond = r.scl_s2 && r.scl_d && r.sda_s2 && !r.sda_d;
  assign fault_active = r.ot_s2 || r.uv_s2;
  assign pin_enable_mode = !r.pin_drive_active && r.en_s2; // RQ21

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic wr_stb;
    logic tsd_set_wr;
    logic tsd_clr_wr;
    logic tsd_event;
    logic [7:0] rd_byte;
    wr_stb = 1'b0;
    tsd_set_wr = 1'b0;
    tsd_clr_wr = 1'b0;
    tsd_event = 1'b0;
    rd_byte = 8'h00;
    n = r;
    n.scl_s1 = I_SCL;
    n.scl_s2 = r.scl_s1;
    n.scl_d = r.scl_s2;
    n.sda_s1 = I_SDA;
    n.sda_s2 = r.sda_s1;
    n.sda_d = r.sda_s2;
    n.ot_s1 = I_OVERTEMP;
    n.ot_s2 = r.ot_s1;
    n.ot_d = r.ot_s2;
    n.uv_s1 = I_UNDERVOLTAGE_LOCKOUT;
    n.uv_s2 = r.uv_s1;
    n.en_s1 = I_EN_PIN;
    n.en_s2 = r.en_s1;
    n.pg_s1 = I_POWER_GOOD;
    n.pg_s2 = r.pg_s1;

    // Serial slave; timing is oversampled, so both bus speeds work
    if (scl_rise && (r.st == PCR_ST_ADDR || r.st == PCR_ST_WRITE)) begin // RQ4
      n.shift = {r.shift[6:0], r.sda_s2};
      n.bit_cnt = r.bit_cnt + 4'h1;
    end
    unique case (r.st)
      PCR_ST_IDLE: begin
        n.sda_oe = 1'b0;
      end
      PCR_ST_ADDR: begin
        if (scl_fall && r.bit_cnt == 4'h8) begin
          if (r.shift[7:1] == PCR_SLAVE_ADDR) begin // RQ5
            n.rw = r.shift[0]; // RQ6
            n.sda_oe = 1'b1;
            n.st = PCR_ST_ADDR_ACK;
          end else begin
            n.st = PCR_ST_IDLE;
          end
        end
      end
      PCR_ST_ADDR_ACK: begin
        if (scl_fall) begin
          n.bit_cnt = 4'h0;
          if (r.rw) begin
            rd_byte = read_reg(r); // RQ22
            n.shift = rd_byte;
            n.sda_oe = !rd_byte[7];
            n.st = PCR_ST_READ;
          end else begin
            n.have_idx = 1'b0;
            n.sda_oe = 1'b0;
            n.st = PCR_ST_WRITE;
          end
        end
      end
      PCR_ST_WRITE: begin
        if (scl_fall && r.bit_cnt == 4'h8) begin
          if (!r.have_idx) begin
            n.idx = r.shift; // RQ22
            n.have_idx = 1'b1;
            n.sda_oe = 1'b1;
          end else if (!fault_active) begin
            wr_stb = 1'b1;
            n.sda_oe = 1'b1;
          end else begin
            n.sda_oe = 1'b0; // RQ13
          end
          n.st = PCR_ST_WRITE_ACK;
        end
      end
      PCR_ST_WRITE_ACK: begin
        if (scl_fall) begin
          n.sda_oe = 1'b0;
          n.bit_cnt = 4'h0;
          n.st = PCR_ST_WRITE;
        end
      end
      PCR_ST_READ: begin
        if (scl_fall) begin
          if (r.bit_cnt == 4'h7) begin
            n.sda_oe = 1'b0;
            n.st = PCR_ST_READ_ACK;
          end else begin
            n.shift = {r.shift[6:0], 1'b0};
            n.sda_oe = !r.shift[6];
            n.bit_cnt = r.bit_cnt + 4'h1;
          end
        end
      end
      PCR_ST_READ_ACK: begin
        if (scl_rise) begin
          n.master_ack = !r.sda_s2;
        end
        if (scl_fall) begin
          if (r.master_ack) begin
            n.idx = r.idx + 8'h01;
            n.shift = read_reg(n);
            n.sda_oe = !n.shift[7];
            n.bit_cnt = 4'h0;
            n.st = PCR_ST_READ;
          end else begin
            n.st = PCR_ST_IDLE;
          end
        end
      end
    endcase
    if (start_cond) begin // RQ22
      n.st = PCR_ST_ADDR;
      n.bit_cnt = 4'h0;
      n.sda_oe = 1'b0;
    end else if (stop_cond) begin
      n.st = PCR_ST_IDLE;
      n.sda_oe = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes; index steps on so bursts fill consecutive registers
    if (wr_stb) begin
      n.idx = r.idx + 8'h01;
      unique case (r.idx)
        PCR_OFS_BUCK_A_VSEL: n.vsel_a = r.shift[2:0]; // RQ19
        PCR_OFS_BUCK_B_LIN_VSEL: begin
          n.vsel_b = r.shift[7:4];
          n.vsel_l = r.shift[3:0];
        end
        PCR_OFS_REG_EN_STATUS: begin
          if (!r.thermal_fault_flag) begin
            n.cmd_en = r.shift[7:4]; // RQ10 RQ11
          end
          n.force_sd = r.shift[PCR_BIT_FORCE_SD];
        end
        PCR_OFS_OP_CTRL: begin
          n.sync_sel = r.shift[PCR_BIT_EXT_9M6:PCR_BIT_SYNC_COUPLING_AC_SELECT]; // RQ20 RQ3
          n.link = r.shift[3:1];
          tsd_set_wr = r.shift[PCR_BIT_THERMAL];
          tsd_clr_wr = !r.shift[PCR_BIT_THERMAL];
        end
        PCR_OFS_EN_PIN_CTRL: begin
          n.pin_drive_active = r.shift[PCR_BIT_PIN_DRV_ACT]; // RQ21
          n.pin_drive_level = r.shift[PCR_BIT_PIN_DRV_LVL];
        end
        default: begin
        end
      endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Thermal fault: set wins over a clear in the same cycle
    tsd_event = (r.ot_s2 && !r.ot_d) || tsd_set_wr; // RQ14
    if (tsd_clr_wr) begin
      n.thermal_fault_flag = 1'b0;
    end
    if (tsd_event) begin
      n.thermal_fault_flag = 1'b1; // RQ9 RQ16
      n.cmd_en = PCR_RST_CMD_EN; // RQ12
    end

    // Pin-mode sequencer restarts from scratch after any shutdown
    if (!pin_enable_mode || fault_active || tsd_event) begin // RQ15
      n.seq_step = 2'h0;
      n.seq_cnt = 12'h000;
    end else if (r.seq_step != PCR_SEQ_LAST) begin
      if (r.seq_cnt == 12'(PCR_SEQ_STEP_CYC - 1)) begin
        n.seq_step = r.seq_step + 2'h1;
        n.seq_cnt = 12'h000;
      end else begin
        n.seq_cnt = r.seq_cnt + 12'h001;
      end
    end

    // Regulator 0 is buck A, 1 buck B, 2 the linear regulator
    for (int i = 0; i < 3; i++) begin
      n.reg_en[i] = !fault_active && !tsd_event // RQ7 RQ8
        && ((r.seq_step > 2'(i)) || r.cmd_en[3 - i] || r.cmd_en[0]);
    end
    n.shutdown_out_n = !r.force_sd
      && ((r.pg_s2 | ~{r.link[0], r.link[1], r.link[2]}) == 3'h7);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fuse codes captured by the clocked reset, not by an async path
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      r <= '0;
      r.scl_s1 <= 1'b1;
      r.scl_s2 <= 1'b1;
      r.scl_d <= 1'b1;
      r.sda_s1 <= 1'b1;
      r.sda_s2 <= 1'b1;
      r.sda_d <= 1'b1;
      r.st <= PCR_ST_IDLE;
      r.vsel_a <= I_FUSE_BUCK_A_VCODE; // RQ19
      r.vsel_b <= I_FUSE_BUCK_B_VCODE;
      r.vsel_l <= I_FUSE_LINEAR_VCODE;
      r.cmd_en <= PCR_RST_CMD_EN;
      r.sync_sel <= PCR_RST_SYNC_SEL;
      r.link <= PCR_RST_LINK;
      r.shutdown_out_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  pcr_switch_ctrl u_switch (
    .i_clk(I_CLK),
    .i_srst(I_SRST),
    .i_sync(I_SYNC),
    .i_sel_9m6(r.sync_sel[2]),
    .i_sel_19m2(r.sync_sel[1]),
    .i_buck_en(r.reg_en[1:0]),
    .i_pwm(I_PWM),
    .i_peak_limit(I_PEAK_LIMIT),
    .i_zero_current(I_ZERO_CURRENT),
    .o_sw_clk(O_SW_CLK),
    .o_ext_active(O_EXT_SYNC_ACTIVE),
    .o_hs_on(O_HS_ON),
    .o_ls_on(O_LS_ON)
  );

  // Open-drain data: the driven level is always low
  assign O_SDA_OUT = 1'b0;
  assign O_SDA_OE = r.sda_oe;
  assign O_EN_PIN_OUT = r.pin_drive_level;
  assign O_EN_PIN_OE = r.pin_drive_active;
  assign O_REG_ENABLE = r.reg_en;
  assign O_SHUTDOWN_OUT_N = r.shutdown_out_n;
  assign O_BUCK_A_VCODE = r.vsel_a;
  assign O_BUCK_B_VCODE = r.vsel_b;
  assign O_LINEAR_VCODE = r.vsel_l;
  assign O_SYNC_COUPLING_AC_SELECT_SELECT = r.sync_sel[0]; // RQ3

endmodule

`default_nettype wire

// ---- pcr_i2c_host.sv ----
/*
 * Serial-bus master model standing for the application processor.
 * Assumes the bench resolves the data line with a pull-up.
 */
`timescale 1ns/1ps
`default_nettype none

module pcr_i2c_host (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  ////////////////////////////////////////
  // 64 cycles a bit, just under 400 kHz
  task automatic q();
    repeat (16) @(posedge clk);
    #1;
  endtask
  // Also serves as repeated start
  task automatic start();
    sda_low = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic stop();
    sda_low = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b0;
    q();
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    q();
    scl = 1'b1;
    q();
    r = sda;
    q();
    scl = 1'b0;
    q();
  endtask
  // Ninth bit nb: 1 releases for device ack or sends nack
  task automatic xfer(input logic [7:0] d, input logic nb,
      output logic [7:0] r, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(nb, b);
    ack = !b;
  endtask
endmodule

`default_nettype wire

// ---- pcr_pkg.sv ----
/*
 * Shared constants and state types of the power-management control logic:
 * bus address, register offsets, field positions, timing counts, state types.
 * Assumes a single 25 MHz clock domain and synchronous active-high reset.
 */
package pcr_pkg;

  localparam logic [6:0] PCR_SLAVE_ADDR = 7'h14;

  localparam logic [7:0] PCR_OFS_REVISION = 8'h00;
  localparam logic [7:0] PCR_OFS_BUCK_A_VSEL = 8'h01;
  localparam logic [7:0] PCR_OFS_BUCK_B_LIN_VSEL = 8'h02;
  localparam logic [7:0] PCR_OFS_REG_EN_STATUS = 8'h03;
  localparam logic [7:0] PCR_OFS_OP_CTRL = 8'h04;
  localparam logic [7:0] PCR_OFS_EN_PIN_CTRL = 8'h05;

  // Field positions
  localparam int PCR_BIT_EXT_9M6 = 6;
  localparam int PCR_BIT_EXT_19M2 = 5;
  localparam int PCR_BIT_SYNC_COUPLING_AC_SELECT = 4;
  localparam int PCR_BIT_THERMAL = 0;
  localparam int PCR_BIT_FORCE_SD = 0;
  localparam int PCR_BIT_PIN_DRV_ACT = 1;
  localparam int PCR_BIT_PIN_DRV_LVL = 0;

  // Reset values of host-writable fields
  localparam logic [3:0] PCR_RST_CMD_EN = 4'h0;
  localparam logic [2:0] PCR_RST_SYNC_SEL = 3'h0;
  localparam logic [2:0] PCR_RST_LINK = 3'h0;

  // Switching clock dividers
  localparam logic [2:0] PCR_DIV_9M6 = 3'h3;
  localparam logic [2:0] PCR_DIV_19M2 = 3'h6;

  // Pin-enable power-up sequence step
  localparam int PCR_CLK_FREQ_MHZ = 25;
  localparam int PCR_SEQ_STEP_US = 100;
  localparam int PCR_SEQ_STEP_CYC = PCR_SEQ_STEP_US * PCR_CLK_FREQ_MHZ;
  localparam logic [1:0] PCR_SEQ_LAST = 2'h3;

  typedef enum logic [2:0] {
    PCR_ST_IDLE = 3'b000,
    PCR_ST_ADDR = 3'b001,
    PCR_ST_ADDR_ACK = 3'b010,
    PCR_ST_WRITE = 3'b011,
    PCR_ST_WRITE_ACK = 3'b100,
    PCR_ST_READ = 3'b101,
    PCR_ST_READ_ACK = 3'b110
  } pcr_i2c_state_t;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    logic ot_s1;
    logic ot_s2;
    logic ot_d;
    logic uv_s1;
    logic uv_s2;
    logic en_s1;
    logic en_s2;
    logic [2:0] pg_s1;
    logic [2:0] pg_s2;
    pcr_i2c_state_t st;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic rw;
    logic have_idx;
    logic master_ack;
    logic [7:0] idx;
    logic sda_oe;
    logic [2:0] vsel_a;
    logic [3:0] vsel_b;
    logic [3:0] vsel_l;
    logic [3:0] cmd_en;
    logic force_sd;
    logic [2:0] sync_sel;
    logic [2:0] link;
    logic thermal_fault_flag;
    logic pin_drive_active;
    logic pin_drive_level;
    logic [1:0] seq_step;
    logic [11:0] seq_cnt;
    logic [2:0] reg_en;
    logic shutdown_out_n;
  } pcr_state_t;

  typedef struct packed {
    logic sync_s1;
    logic sync_s2;
    logic sync_d;
    logic [1:0] pwm_s1;
    logic [1:0] pwm_s2;
    logic [1:0] lim_s1;
    logic [1:0] lim_s2;
    logic [1:0] zero_s1;
    logic [1:0] zero_s2;
    logic [1:0] limit_hold;
    logic [2:0] div_cnt;
    logic sw_clk;
    logic ext_active;
    logic [1:0] hs_on;
    logic [1:0] ls_on;
  } pcr_sw_state_t;

endpackage

// ---- pcr_switch_ctrl.sv ----
/*
 * Switching-clock divider for the external sync input and per-buck
 * current-limit switch control.
 * Assumes all pin inputs are asynchronous and the enables come from the
 * same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module pcr_switch_ctrl
  import pcr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_sync,
  input wire logic i_sel_9m6,
  input wire logic i_sel_19m2,
  input wire logic [1:0] i_buck_en,
  input wire logic [1:0] i_pwm,
  input wire logic [1:0] i_peak_limit,
  input wire logic [1:0] i_zero_current,
  output logic o_sw_clk,
  output logic o_ext_active,
  output logic [1:0] o_hs_on,
  output logic [1:0] o_ls_on
);

  pcr_sw_state_t r;
  pcr_sw_state_t n;
  logic [2:0] div_n;
  logic [2:0] cnt_n;
  wire [1:0] hold_n;
  wire [1:0] hs_n;
  wire [1:0] ls_n;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = r;
    n.sync_s1 = i_sync;
    n.sync_s2 = r.sync_s1;
    n.sync_d = r.sync_s2;
    n.pwm_s1 = i_pwm;
    n.pwm_s2 = r.pwm_s1;
    n.lim_s1 = i_peak_limit;
    n.lim_s2 = r.lim_s1;
    n.zero_s1 = i_zero_current;
    n.zero_s2 = r.zero_s1;
    // Exactly one select must be set; both or neither falls back internal
    n.ext_active = i_sel_9m6 ^ i_sel_19m2;
    div_n = i_sel_9m6 ? PCR_DIV_9M6 : PCR_DIV_19M2; // RQ1 RQ2
    cnt_n = r.div_cnt;
    if (!r.ext_active) begin
      cnt_n = 3'h0;
    end else if (r.sync_s2 && !r.sync_d) begin
      cnt_n = (r.div_cnt >= div_n - 3'h1) ? 3'h0 : r.div_cnt + 3'h1; // RQ1 RQ2
    end
    n.div_cnt = cnt_n;
    n.sw_clk = r.ext_active && (cnt_n < {1'b0, div_n[2:1]});
    n.limit_hold = hold_n;
    n.hs_on = hs_n;
    n.ls_on = ls_n;
  end

  // Limit holds the low side on until the inductor current is zero
  // A new limit event wins over the zero-current release
  for (genvar b = 0; b < 2; b++) begin : g_buck
    assign hold_n[b] = i_buck_en[b]
      && (r.lim_s2[b] || (r.limit_hold[b] && !r.zero_s2[b])); // RQ17
    assign hs_n[b] = i_buck_en[b] && r.pwm_s2[b] && !hold_n[b]; // RQ17
    assign ls_n[b] = i_buck_en[b] && (!r.pwm_s2[b] || hold_n[b]); // RQ17
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign o_sw_clk = r.sw_clk;
  assign o_ext_active = r.ext_active;
  assign o_hs_on = r.hs_on;
  assign o_ls_on = r.ls_on;

endmodule

`default_nettype wire

// ---- tb_top.sv ----
/*
 * Self-checking bench for the power control block.
 * Assumes package, design, checker and host model compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

bind pcr_control_regs pcr_checker pcr_checker_inst (.I_CLK(I_CLK), .I_SRST(I_SRST),
  .I_SCL(I_SCL), .I_UNDERVOLTAGE_LOCKOUT(I_UNDERVOLTAGE_LOCKOUT),
  .I_OVERTEMP(I_OVERTEMP), .I_PEAK_LIMIT(I_PEAK_LIMIT), .I_ZERO_CURRENT(I_ZERO_CURRENT),
  .O_SDA_OUT(O_SDA_OUT), .O_SDA_OE(O_SDA_OE), .O_EN_PIN_OE(O_EN_PIN_OE),
  .O_REG_ENABLE(O_REG_ENABLE), .O_SHUTDOWN_OUT_N(O_SHUTDOWN_OUT_N), .O_SW_CLK(O_SW_CLK),
  .O_EXT_SYNC_ACTIVE(O_EXT_SYNC_ACTIVE), .O_HS_ON(O_HS_ON), .O_LS_ON(O_LS_ON));

module tb_top;
  import pcr_pkg::*;
  localparam logic [2:0] rev_major = 3'h5; // Arbitrary value
  localparam logic [2:0] rev_minor = 3'h2; // Arbitrary value
  localparam logic [1:0] rev_opt = 2'h1; // Arbitrary value
  localparam logic [7:0] rev_all = {rev_major, rev_minor, rev_opt};
  logic clk = 1'b0;
  logic srst, undervoltage_lockout, otemp, sync, en_drv, scl, host_low, sda_w, en_w, a;
  logic sda_oe, sda_out, en_out, en_oe, shdn_n, sync_coupling_ac_select, sw_clk, ext_act;
  logic [1:0] peak, zero, hs, ls;
  logic [2:0] fa, va, reg_en, code;
  logic [2:0] sdiv = 3'h0;
  logic [3:0] fb, fl, vb, vl;
  logic [7:0] got_val, r;
  logic [31:0] seed, rnd;
  logic [7:0] exp_q[$];
  int err_count = 0;
  int total_checks = 0;
  int n;
  event got_ev;

  always #20 clk = ~clk;
  // Sync source runs free at one eighth of the clock
  always @(posedge clk) begin
    #1;
    sdiv = sdiv + 3'h1;
    sync = sdiv[2];
  end
  // Pull-up on the data line; en_drv drives the enable pin unless the device drives it
  assign sda_w = !(host_low || sda_oe);
  assign en_w = en_oe ? en_out : en_drv;

  pcr_i2c_host pcr_i2c_host_inst (.clk(clk), .sda(sda_w), .scl(scl), .sda_low(host_low));
  pcr_control_regs #(.MAJOR_REV(rev_major), .MINOR_REV(rev_minor), .OPTION_CODE(rev_opt))
    pcr_control_regs_inst (.I_CLK(clk), .I_SRST(srst), .I_SCL(scl), .I_SDA(sda_w),
    .O_SDA_OUT(sda_out), .O_SDA_OE(sda_oe), .I_EN_PIN(en_w), .O_EN_PIN_OUT(en_out),
    .O_EN_PIN_OE(en_oe), .I_UNDERVOLTAGE_LOCKOUT(undervoltage_lockout), .I_OVERTEMP(otemp),
    .I_POWER_GOOD(3'h7), .I_FUSE_BUCK_A_VCODE(fa), .I_FUSE_BUCK_B_VCODE(fb),
    .I_FUSE_LINEAR_VCODE(fl), .I_SYNC(sync), .I_PWM(2'h3), .I_PEAK_LIMIT(peak),
    .I_ZERO_CURRENT(zero), .O_REG_ENABLE(reg_en), .O_SHUTDOWN_OUT_N(shdn_n),
    .O_BUCK_A_VCODE(va), .O_BUCK_B_VCODE(vb), .O_LINEAR_VCODE(vl),
    .O_SYNC_COUPLING_AC_SELECT_SELECT(sync_coupling_ac_select), .O_SW_CLK(sw_clk), .O_EXT_SYNC_ACTIVE(ext_act),
    .O_HS_ON(hs), .O_LS_ON(ls));
  ////////////////////////////////////////
  task automatic print_verdict();
    if (err_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] e);
    total_checks++;
    if (seen !== e) begin
      err_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, e);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic sel(input logic [7:0] idx, output logic ack);
    pcr_i2c_host_inst.start();
    pcr_i2c_host_inst.xfer({PCR_SLAVE_ADDR, 1'b0}, 1'b1, r, ack);
    pcr_i2c_host_inst.xfer(idx, 1'b1, r, a);
  endtask
  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d, input logic dack);
    logic ack;
    sel(idx, ack);
    if (dack) chk({7'h0, ack}, 8'h01);
    pcr_i2c_host_inst.xfer(d, 1'b1, r, ack);
    chk({7'h0, ack}, {7'h0, dack});
    pcr_i2c_host_inst.stop();
  endtask
  task automatic rd_reg(input logic [7:0] idx, input logic [7:0] e);
    exp_q.push_back(e);
    sel(idx, a);
    pcr_i2c_host_inst.start();
    pcr_i2c_host_inst.xfer({PCR_SLAVE_ADDR, 1'b1}, 1'b1, r, a);
    pcr_i2c_host_inst.xfer(8'hff, 1'b1, got_val, a);
    pcr_i2c_host_inst.stop();
    -> got_ev;
  endtask
  task automatic sw_rise(output int c);
    logic p;
    c = 0;
    p = sw_clk;
    while (!(sw_clk === 1'b1 && p === 1'b0) && c < 400) begin
      p = sw_clk;
      tick(1);
      c++;
    end
    if (c >= 400) begin
      err_count++;
      print_verdict();
    end
  endtask
  task automatic wait_en(input logic [2:0] e, output int c);
    c = 0;
    while (reg_en !== e && c < 9000) begin
      tick(1);
      c++;
    end
    if (c >= 9000) begin
      err_count++;
      print_verdict();
    end
  endtask
  ////////////////////////////////////////
  initial forever begin
    @(got_ev);
    chk(got_val, exp_q.pop_front());
  end

  initial begin
    {srst, undervoltage_lockout, otemp, en_drv, peak, zero} = {1'b1, 7'h0};
    seed = 32'hec67;
    rnd = $random(seed);
    {code, fl, fb, fa} = rnd[13:0];
    if (code > 3'h5) code = code - 3'h3;
    repeat (4) @(posedge clk);
    #1;
    srst = 1'b0;
    tick(2);
    chk({reg_en, en_oe, shdn_n, va}, {3'h0, 1'b0, 1'b1, fa});
    chk({vb, vl}, {fb, fl});
    rd_reg(PCR_OFS_REVISION, rev_all);
    wr_reg(PCR_OFS_REVISION, 8'h00, 1'b1);
    rd_reg(PCR_OFS_REVISION, rev_all);
    rd_reg(8'h06, 8'h00);
    sel(8'h00, a);
    pcr_i2c_host_inst.start();
    pcr_i2c_host_inst.xfer({7'h15, 1'b0}, 1'b1, r, a);
    chk({7'h0, a}, 8'h00);
    pcr_i2c_host_inst.stop();
    wr_reg(PCR_OFS_BUCK_A_VSEL, {5'h0, code}, 1'b1);
    chk({5'h0, va}, {5'h0, code});
    for (int k = 0; k < 2; k++) begin
      wr_reg(PCR_OFS_OP_CTRL, k ? 8'h20 : 8'h40, 1'b1);
      rd_reg(PCR_OFS_OP_CTRL, k ? 8'h20 : 8'h40);
      sw_rise(n);
      sw_rise(n);
      chk({7'h0, ext_act}, 8'h01);
      chk(8'(n), k ? 8'd48 : 8'd24);
    end
    wr_reg(PCR_OFS_OP_CTRL, 8'h70, 1'b1);
    tick(8);
    chk({5'h0, sync_coupling_ac_select, ext_act, sw_clk}, 8'h04);
    wr_reg(PCR_OFS_OP_CTRL, 8'h00, 1'b1);
    chk({7'h0, sync_coupling_ac_select}, 8'h00);
    wr_reg(PCR_OFS_BUCK_B_LIN_VSEL, rnd[21:14], 1'b1);
    chk({vb, vl}, rnd[21:14]);
    wr_reg(PCR_OFS_REG_EN_STATUS, 8'h01, 1'b1);
    rd_reg(PCR_OFS_REG_EN_STATUS, 8'h0f);
    chk({7'h0, shdn_n}, 8'h00);
    wr_reg(PCR_OFS_REG_EN_STATUS, 8'h80, 1'b1);
    chk({5'h0, reg_en}, 8'h01);
    peak = 2'b01;
    tick(6);
    chk({6'h0, hs[0], ls[0]}, 8'h01);
    peak = 2'b00;
    tick(6);
    chk({6'h0, hs[0], ls[0]}, 8'h01);
    zero = 2'b01;
    tick(6);
    chk({7'h0, ls[0]}, 8'h00);
    zero = 2'b00;
    undervoltage_lockout = 1'b1;
    tick(6);
    chk({5'h0, reg_en}, 8'h00);
    wr_reg(PCR_OFS_BUCK_A_VSEL, 8'h00, 1'b0);
    chk({5'h0, va}, {5'h0, code});
    undervoltage_lockout = 1'b0;
    // Overtemperature in command mode
    otemp = 1'b1;
    tick(6);
    chk({5'h0, reg_en}, 8'h00);
    otemp = 1'b0;
    tick(6);
    rd_reg(PCR_OFS_OP_CTRL, 8'h01);
    chk({5'h0, reg_en}, 8'h00);
    wr_reg(PCR_OFS_REG_EN_STATUS, 8'h80, 1'b1);
    chk({5'h0, reg_en}, 8'h00);
    wr_reg(PCR_OFS_OP_CTRL, 8'h00, 1'b1);
    wr_reg(PCR_OFS_REG_EN_STATUS, 8'h80, 1'b1);
    chk({5'h0, reg_en}, 8'h01);
    wr_reg(PCR_OFS_OP_CTRL, 8'h01, 1'b1);
    chk({5'h0, reg_en}, 8'h00);
    rd_reg(PCR_OFS_OP_CTRL, 8'h01);
    wr_reg(PCR_OFS_OP_CTRL, 8'h00, 1'b1);
    wr_reg(PCR_OFS_REG_EN_STATUS, 8'h00, 1'b1);
    wr_reg(PCR_OFS_EN_PIN_CTRL, 8'h03, 1'b1);
    chk({6'h0, en_oe, en_out}, 8'h03);
    wr_reg(PCR_OFS_EN_PIN_CTRL, 8'h00, 1'b1);
    // Pin mode sequencing and automatic recovery
    en_drv = 1'b1;
    wait_en(3'b001, n);
    wait_en(3'b011, n);
    chk({7'h0, 1'(n == PCR_SEQ_STEP_CYC)}, 8'h01);
    wait_en(3'b111, n);
    otemp = 1'b1;
    tick(6);
    chk({5'h0, reg_en}, 8'h00);
    otemp = 1'b0;
    wait_en(3'b111, n);
    rd_reg(PCR_OFS_OP_CTRL, 8'h01);
    tick(4);
    print_verdict();
  end
endmodule

`default_nettype wire
